// *** rtl/esr_pkg.sv ***
// Package of constants and types for the exception stacking and token block.
package esr_pkg;

    // Word counts of the frame parts.
    localparam int unsigned BASIC_WORDS    = 8;       // Caller-saved integer.
    localparam int unsigned FP_BASIC_WORDS = 18;      // Sixteen singles, status, predicate.
    localparam int unsigned ADD_WORDS      = 10;      // Signature, reserved, eight callee.
    localparam int unsigned FP_ADD_WORDS   = 16;      // Callee-saved singles.

    // Integrity signature values; bit 0 marks a frame with FP context.
    localparam logic [31:0] SIG_NO_FP  = 32'hFEFA125A; // Frame without FP.
    localparam logic [31:0] SIG_WITH_FP = 32'hFEFA125B; // Frame with FP.

    // Return token layout.
    localparam int unsigned TOK_STACK_BIT = 6;        // Secure stack holds frame.
    localparam int unsigned TOK_DEFAULT_CALLEE_PUSH_FLAG_BIT  = 5;        // Default callee stacking.
    localparam int unsigned TOK_WORLD_BIT = 0;        // Taken to secure state.
    localparam int unsigned TOK_FTYPE_BIT = 4;        // 1 when no FP frame.
    localparam int unsigned TOK_MODE_BIT  = 3;        // 1 for Thread background.
    localparam int unsigned TOK_SPSEL_BIT = 2;        // 1 for process stack.
    localparam logic [31:0] TOK_BASE      = 32'hFFFFFF80; // Fixed upper bits.
    localparam logic [31:0] TOK_MATCH     = 32'hFF000000; // Prefix of a token.

    // Word register selectors sent to the register banks.
    localparam logic [5:0] SEL_INT_BASE  = 6'h00;     // Integer caller words.
    localparam logic [5:0] SEL_FP_BASE   = 6'h08;     // FP caller words.
    localparam logic [5:0] SEL_SIG       = 6'h1A;     // Signature word.
    localparam logic [5:0] SEL_CALLEE    = 6'h1B;     // Integer callee words.
    localparam logic [5:0] SEL_FP_CALLEE = 6'h24;     // FP callee words.

    // Sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_BASIC  = 3'b001,
        ST_FPB    = 3'b010,
        ST_ADD    = 3'b011,
        ST_FPADD  = 3'b100,
        ST_TOKEN  = 3'b101,
        ST_RETCHK = 3'b110,
        ST_WIPE   = 3'b111
    } esr_state_type;

endpackage

// *** rtl/esr_word_counter.sv ***
// Down counter that paces the words of one frame part.
`timescale 1ns/1ns
`default_nettype none
module esr_word_counter
    import esr_pkg::*;
#(
    parameter int unsigned WIDTH = 5     // Counter width.
) (
    input  wire logic             i_clk,    // Core clock.
    input  wire logic             i_rst_n,  // Asynchronous reset, low.
    input  wire logic             i_load,   // Load a new count.
    input  wire logic [WIDTH-1:0] i_count,  // Words to run.
    input  wire logic             i_step,   // One word moved.
    output logic [WIDTH-1:0]      o_index,  // Index of current word.
    output logic                  o_last    // Current word is the last.
);

    logic [WIDTH-1:0] left_q;   // Words still to move.

    // Index climbs while the remaining count falls.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            left_q  <= '0;
            o_index <= '0;
        end else if (i_load) begin
            left_q  <= i_count;
            o_index <= '0;
        end else if (i_step && left_q != '0) begin
            left_q  <= left_q - WIDTH'(1);
            o_index <= o_index + WIDTH'(1);
        end
    end

    // Last word when one remains.
    assign o_last = (left_q == WIDTH'(1));

endmodule
`default_nettype wire

// *** rtl/esr_token_check.sv ***
// Return-token consistency checker used on exception return.
`timescale 1ns/1ns
`default_nettype none
module esr_token_check
    import esr_pkg::*;
(
    input  wire logic [31:0] i_token,      // Token loaded into the PC.
    input  wire logic        i_sec_ext,    // Security extension present.
    input  wire logic        i_cur_secure, // Handler runs secure.
    input  wire logic        i_sig_ok,     // Stacked signature matched.
    input  wire logic        i_need_sig,   // Signature must be checked.
    output logic             o_ok,         // Token consistent.
    output logic             o_bad_state,  // Token bits wrong for state.
    output logic             o_bad_sig     // Signature mismatch.
);

    // A non-secure return may not claim secure target or extra stacking.
    always_comb begin
        o_bad_state = 1'b0;
        if (!i_sec_ext) begin
            o_bad_state = i_token[TOK_STACK_BIT] | i_token[TOK_WORLD_BIT]
                        | !i_token[TOK_DEFAULT_CALLEE_PUSH_FLAG_BIT];
        end else if (!i_cur_secure) begin
            o_bad_state = i_token[TOK_WORLD_BIT] | !i_token[TOK_DEFAULT_CALLEE_PUSH_FLAG_BIT];
        end
        o_bad_sig = i_need_sig & !i_sig_ok;
        o_ok      = !o_bad_state & !o_bad_sig;
    end

endmodule
`default_nettype wire

// *** rtl/esr_stacker.sv ***
// Exception entry stacking, return-token builder and return checking.
`timescale 1ns/1ns
`default_nettype none
module esr_stacker
    import esr_pkg::*;
#(
    parameter bit SEC_EXT = 1'b1         // Security extension fitted.
) (
    input  wire logic        i_clk,           // Core clock.
    input  wire logic        i_rst_n,         // Asynchronous reset, low.
    input  wire logic        i_entry,         // Exception entry request.
    input  wire logic        i_tail_chain,    // Entry is a tail-chain.
    input  wire logic        i_late_arrival,  // Late higher-priority swap.
    input  wire logic        i_target_secure, // Exception targets secure.
    input  wire logic        i_bg_secure,     // Background code secure.
    input  wire logic        i_bg_thread,     // Background in Thread mode.
    input  wire logic        i_bg_psp,        // Background used process SP.
    input  wire logic        i_fp_active,     // FP context active.
    input  wire logic        i_fp_lazy,       // Defer FP caller stacking.
    input  wire logic        i_fp_callee_protect_bit, // FP callee protect.
    input  wire logic        i_fp_wipe_on_return_bit, // Wipe FP on return.
    input  wire logic [31:0] i_sp_main_s,     // Secure main SP.
    input  wire logic [31:0] i_sp_proc_s,     // Secure process SP.
    input  wire logic [31:0] i_sp_main_ns,    // Non-secure main SP.
    input  wire logic [31:0] i_sp_proc_ns,    // Non-secure process SP.
    input  wire logic [31:0] i_reg_rdata,     // Word from register bank.
    input  wire logic        i_mem_ready,     // Stack memory accepts.
    input  wire logic        i_pc_load,       // Handler loads the PC.
    input  wire logic [31:0] i_pc_value,      // Value loaded into the PC.
    input  wire logic        i_cur_secure,    // Running handler is secure.
    input  wire logic [31:0] i_stacked_sig,   // Signature read on unstack.
    output logic [5:0]       o_reg_sel,       // Register bank word select.
    output logic             o_mem_write,     // Stack write strobe.
    output logic [31:0]      o_mem_addr,      // Stack write address.
    output logic [31:0]      o_mem_wdata,     // Stack write data.
    output logic             o_lr_write,      // Link register write pulse.
    output logic [31:0]      o_lr_value,      // Token written to LR.
    output logic             o_handler_msp_s, // Handler uses secure main SP.
    output logic             o_lazy_pending,  // FP caller context deferred.
    output logic             o_ret_start,     // Return sequence starts.
    output logic             o_ret_fault,     // Return integrity failure.
    output logic             o_fp_wipe,       // Clear FP registers pulse.
    output logic             o_busy,          // Sequence in progress.
    output logic             o_callee_stacked // Callee context on stack.
);

    esr_state_type  state_q;       // Sequencer state.
    logic [31:0]    base_q;        // Top of basic frame.
    logic [31:0]    addr_q;        // Next write address.
    logic           fp_frame_q;    // Frame holds FP context.
    logic           need_add_q;    // Callee context to push.
    logic           need_fpadd_q;  // FP callee context to push.
    logic           stack_sec_q;   // Frame on secure stack.
    logic           default_callee_push_flag_q;        // Default callee stacking.
    logic           world_q;       // Target state secure.
    logic           thread_q;      // Background thread mode.
    logic           psp_q;         // Background process SP.
    logic           callee_q;      // Callee context already on stack.
    logic           wipe_q;        // Wipe on this return.
    logic [4:0]     cnt_load;      // Count for next part.
    logic           cnt_start;     // Start a part.
    logic [4:0]     idx;           // Word index within part.
    logic           last;          // Last word of part.
    logic           step;          // Word written this cycle.
    logic           chk_ok;        // Return token consistent.
    logic           default_add;   // Default rule wants callee context.
    logic           fresh_entry;   // Entry starts a new frame.
    esr_state_type  nxt_part;      // Part after the current one.

    // Selects the SP of the preempted background state.
    function automatic logic [31:0] pick_sp(input logic sec,
                                            input logic process_stack_pointer,
                                            input logic [31:0] ms,
                                            input logic [31:0] ps,
                                            input logic [31:0] mn,
                                            input logic [31:0] pn);
        logic [31:0] r;
        r = sec ? (process_stack_pointer ? ps : ms) : (process_stack_pointer ? pn : mn);
        return r;
    endfunction

    // Recognises a token value.
    function automatic logic is_token(input logic [31:0] v);
        return (v & TOK_MATCH) == TOK_MATCH;
    endfunction

    // Part that follows the current one, given what the frame needs.
    function automatic esr_state_type part_after(input esr_state_type s,
                                                 input logic fpb,
                                                 input logic add,
                                                 input logic fpadd);
        esr_state_type r;
        r = ST_TOKEN;
        if (s == ST_BASIC && fpb) begin
            r = ST_FPB;
        end else if ((s == ST_BASIC || s == ST_FPB) && add) begin
            r = ST_ADD;
        end else if (s != ST_FPADD && fpadd) begin
            r = ST_FPADD;
        end
        return r;
    endfunction

    // Words in one frame part.
    function automatic logic [4:0] part_words(input esr_state_type s);
        return (s == ST_BASIC) ? 5'(BASIC_WORDS)
             : (s == ST_FPB)   ? 5'(FP_BASIC_WORDS)
             : (s == ST_ADD)   ? 5'(ADD_WORDS) : 5'(FP_ADD_WORDS);
    endfunction

    // Start of the next part, just below the part that has finished.
    function automatic logic [31:0] next_start(input logic [31:0] a,
                                               input logic [4:0]  cur,
                                               input logic [4:0]  nw);
        return a + 32'h00000004 - {25'h0, cur, 2'b00} - {25'h0, nw, 2'b00};
    endfunction

    assign default_add = SEC_EXT && i_bg_secure && !i_target_secure;
    assign fresh_entry = !i_tail_chain && !i_late_arrival;
    assign nxt_part    = part_after(state_q, fp_frame_q && !i_fp_lazy,
                                    need_add_q, need_fpadd_q);
    assign step        = o_mem_write && i_mem_ready;

    // Pacing counter for the words of each part.
    esr_word_counter #(
        .WIDTH  (5)
    ) u_cnt (
        .i_clk  (i_clk),
        .i_rst_n(i_rst_n),
        .i_load (cnt_start),
        .i_count(cnt_load),
        .i_step (step),
        .o_index(idx),
        .o_last (last)
    );

    // Token checker for returns.
    esr_token_check u_chk (
        .i_token     (i_pc_value),
        .i_sec_ext   (SEC_EXT),
        .i_cur_secure(i_cur_secure),
        .i_sig_ok    (i_stacked_sig[31:1] == SIG_NO_FP[31:1]),
        .i_need_sig  (SEC_EXT && !i_cur_secure && stack_sec_q && callee_q),
        .o_ok        (chk_ok),
        .o_bad_state (),
        .o_bad_sig   ()
    );

    // Entry decisions: latch frame type and token fields.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fp_frame_q   <= 1'b0;
            need_add_q   <= 1'b0;
            need_fpadd_q <= 1'b0;
            stack_sec_q  <= 1'b0;
            default_callee_push_flag_q       <= 1'b1;
            world_q      <= 1'b0;
            thread_q     <= 1'b1;
            psp_q        <= 1'b0;
            base_q       <= '0;
        end else if (i_entry && state_q == ST_IDLE) begin
            world_q    <= SEC_EXT && i_target_secure;
            // Callee words already stacked on a secure target mean non-default.
            default_callee_push_flag_q     <= !(SEC_EXT && i_target_secure && callee_q
                            && (i_late_arrival || i_tail_chain));
            need_add_q <= default_add
                          && (fresh_entry || !callee_q);
            // FP callee words follow secure background when protected.
            need_fpadd_q <= SEC_EXT && i_bg_secure && i_fp_active
                && i_fp_callee_protect_bit
                && (fresh_entry || (default_add && !callee_q));
            if (fresh_entry) begin
                fp_frame_q  <= i_fp_active;
                stack_sec_q <= SEC_EXT && i_bg_secure;
                thread_q    <= i_bg_thread;
                psp_q       <= i_bg_psp;
                base_q      <= pick_sp(SEC_EXT && i_bg_secure, i_bg_psp,
                                       i_sp_main_s, i_sp_proc_s,
                                       i_sp_main_ns, i_sp_proc_ns);
            end
        end
    end

    // Tracks callee context on the stack; a new frame or unstack clears it.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            callee_q <= 1'b0;
        end else if (state_q == ST_IDLE && i_entry && fresh_entry) begin
            callee_q <= 1'b0;
        end else if (state_q == ST_ADD && step && last) begin
            callee_q <= 1'b1;
        end else if (state_q == ST_RETCHK && !i_entry) begin
            callee_q <= 1'b0;
        end
    end

    // Sequencer: basic, FP caller, callee, FP callee, token.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= ST_IDLE;
            addr_q  <= '0;
            wipe_q  <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (i_entry && (i_tail_chain || i_late_arrival)) begin
                        state_q <= ST_ADD;
                        addr_q  <= base_q - 32'((BASIC_WORDS + ADD_WORDS) * 4)
                                 - (fp_frame_q ? 32'(FP_BASIC_WORDS * 4)
                                               : 32'h00000000);
                    end else if (i_entry) begin
                        state_q <= ST_BASIC;
                        addr_q  <= pick_sp(SEC_EXT && i_bg_secure, i_bg_psp,
                                           i_sp_main_s, i_sp_proc_s,
                                           i_sp_main_ns, i_sp_proc_ns)
                                   - 32'(BASIC_WORDS * 4);
                    end else if (i_pc_load && is_token(i_pc_value)) begin
                        state_q <= ST_RETCHK;
                        wipe_q  <= i_fp_wipe_on_return_bit;
                    end
                end
                ST_BASIC, ST_FPB, ST_ADD, ST_FPADD: begin
                    if (state_q == ST_ADD && !need_add_q) begin
                        state_q <= ST_TOKEN;
                    end else if (step && last) begin
                        state_q <= nxt_part;
                        addr_q  <= next_start(addr_q, part_words(state_q),
                                              part_words(nxt_part));
                    end else if (step) begin
                        addr_q <= addr_q + 32'h00000004;
                    end
                end
                ST_TOKEN:  state_q <= ST_IDLE;
                ST_RETCHK: state_q <= (chk_ok && wipe_q) ? ST_WIPE : ST_IDLE;
                ST_WIPE:   state_q <= ST_IDLE;
            endcase
        end
    end

    // Word count for the part about to start.
    always_comb begin
        cnt_start = 1'b0;
        cnt_load  = part_words(nxt_part);
        if (state_q == ST_IDLE) begin
            cnt_start = i_entry;
            cnt_load  = fresh_entry ? 5'(BASIC_WORDS) : 5'(ADD_WORDS);
        end else if (state_q != ST_FPADD) begin
            cnt_start = step && last;
        end
    end

    // Write port: register select and data, signature first in callee part.
    always_comb begin
        o_mem_write = 1'b0;
        o_reg_sel   = SEL_INT_BASE;
        o_mem_wdata = i_reg_rdata;
        unique case (state_q)
            ST_BASIC: begin
                o_mem_write = 1'b1;
                o_reg_sel   = SEL_INT_BASE + 6'(idx);
            end
            ST_FPB: begin
                o_mem_write = 1'b1;
                o_reg_sel   = SEL_FP_BASE + 6'(idx);
            end
            ST_ADD: begin
                o_mem_write = need_add_q;
                o_reg_sel   = SEL_CALLEE + 6'(idx) - 6'h02;
                if (idx == 5'h00) begin
                    o_reg_sel   = SEL_SIG;
                    o_mem_wdata = fp_frame_q ? SIG_WITH_FP : SIG_NO_FP;
                end else if (idx == 5'h01) begin
                    o_reg_sel   = SEL_INT_BASE;
                    o_mem_wdata = 32'h00000000;
                end
            end
            ST_FPADD: begin
                o_mem_write = 1'b1;
                o_reg_sel   = SEL_FP_CALLEE + 6'(idx);
            end
            default: begin
                o_mem_write = 1'b0;
            end
        endcase
    end

    assign o_mem_addr = addr_q;

    // Token assembly and link register write.
    always_comb begin
        o_lr_value = TOK_BASE;
        o_lr_value[TOK_STACK_BIT] = stack_sec_q;
        o_lr_value[TOK_DEFAULT_CALLEE_PUSH_FLAG_BIT]  = default_callee_push_flag_q;
        o_lr_value[TOK_FTYPE_BIT] = !fp_frame_q;
        o_lr_value[TOK_MODE_BIT]  = thread_q;
        o_lr_value[TOK_SPSEL_BIT] = psp_q;
        o_lr_value[TOK_WORLD_BIT] = world_q;
    end

    assign o_lr_write       = (state_q == ST_TOKEN);
    assign o_handler_msp_s  = world_q;
    assign o_lazy_pending   = fp_frame_q && i_fp_lazy;
    assign o_ret_start      = (state_q == ST_RETCHK) && chk_ok;
    assign o_ret_fault      = (state_q == ST_RETCHK) && !chk_ok;
    assign o_fp_wipe        = (state_q == ST_WIPE);
    assign o_busy           = (state_q != ST_IDLE);
    assign o_callee_stacked = callee_q;

endmodule
`default_nettype wire

// *** test/esr_stacker_chk.sv ***
// Concurrent checks on the stacking block ports.
`timescale 1ns/1ns
`default_nettype none
module esr_stacker_chk
    import esr_pkg::*;
(
    input wire logic        i_clk,        // Clock.
    input wire logic        i_rst_n,      // Reset, low.
    input wire logic        i_entry,      // Entry request.
    input wire logic        i_tail_chain, // Tail-chain entry.
    input wire logic        i_late_arrival, // Late-arrival entry.
    input wire logic        i_mem_ready,  // Memory ready.
    input wire logic        i_pc_load,    // PC load.
    input wire logic [31:0] i_pc_value,   // PC value.
    input wire logic        i_cur_secure, // Handler secure.
    input wire logic        i_fp_wipe_on_return_bit, // Wipe enable.
    input wire logic [5:0]  o_reg_sel,    // Word select.
    input wire logic        o_mem_write,  // Write strobe.
    input wire logic [31:0] o_mem_addr,   // Write address.
    input wire logic [31:0] o_mem_wdata,  // Write data.
    input wire logic        o_lr_write,   // Token pulse.
    input wire logic [31:0] o_lr_value,   // Token.
    input wire logic        o_ret_start,  // Return start.
    input wire logic        o_ret_fault,  // Return fault.
    input wire logic        o_fp_wipe,    // Wipe pulse.
    input wire logic        o_busy        // Busy.
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    AST_ENTRY_STARTS: assert property (i_entry && !o_busy
        && !i_tail_chain && !i_late_arrival |=> o_busy && o_mem_write)
        else $error("entry did not start a frame");
    AST_WRITE_HOLDS: assert property (o_mem_write && !i_mem_ready |=>
        o_mem_write && $stable(o_mem_addr)) else $error("write dropped");
    AST_ENTRY_ENDS: assert property (i_entry && !o_busy
        && !i_tail_chain && !i_late_arrival |->
        ##[9:400] o_lr_write) else $error("no token after entry");
    AST_LR_PULSE: assert property (o_lr_write |=> !o_lr_write)
        else $error("token pulse too long");
    AST_LR_TOKEN: assert property (o_lr_write |->
        o_lr_value[31:7] == TOK_BASE[31:7]) else $error("token prefix");
    AST_SIG_WORD: assert property (o_mem_write && o_reg_sel == SEL_SIG |->
        o_mem_wdata[31:1] == SIG_NO_FP[31:1]) else $error("bad signature");
    AST_RET_SEEN: assert property (i_pc_load && i_pc_value[31:24] == 8'hFF
        && !o_busy && !i_entry |=> o_ret_start || o_ret_fault)
        else $error("token load not seen");
    AST_BRANCH_PLAIN: assert property (i_pc_load &&
        i_pc_value[31:24] != 8'hFF |=> !o_ret_start && !o_ret_fault)
        else $error("plain branch treated as return");
    AST_BAD_WORLD: assert property (i_pc_load && i_pc_value[31:24] == 8'hFF
        && i_pc_value[0] && !i_cur_secure && !o_busy && !i_entry
        |=> o_ret_fault) else $error("secure token from non-secure");
    AST_WIPE_AFTER: assert property (o_ret_start &&
        i_fp_wipe_on_return_bit |=> o_fp_wipe) else $error("no wipe");
    AST_WIPE_CAUSE: assert property (o_fp_wipe |-> $past(o_ret_start)
        && i_fp_wipe_on_return_bit) else $error("stray wipe");
endmodule
bind esr_stacker esr_stacker_chk chk_u (.*);
`default_nettype wire

// *** test/esr_bank_mem_model.sv ***
// Register bank and stack memory facing the stacking block.
`timescale 1ns/1ns
`default_nettype none
module esr_bank_mem_model (
    input  wire logic        i_clk,   // Clock.
    input  wire logic        i_stall, // Slow memory.
    input  wire logic [5:0]  i_sel,   // Word select.
    input  wire logic        i_wr,    // Write strobe.
    input  wire logic [31:0] i_addr,  // Address.
    input  wire logic [31:0] i_wdata, // Data.
    output logic      [31:0] o_rdata, // Register word.
    output logic             o_ready  // Write taken.
);
    logic [31:0] mem [logic [31:0]]; // Stack by address.
    int          n_wr = 0;           // Words stored.
    logic        tick_q = 1'b0;      // Stall phase.
    // Each word carries its select, so frame order shows in memory.
    assign o_rdata = 32'hC0DE0000 | {26'h0, i_sel};
    // While stalling, only every other cycle accepts a word.
    assign o_ready = !i_stall || tick_q;
    always @(posedge i_clk) begin
        tick_q <= !tick_q;
        if (i_wr && o_ready) begin
            mem[i_addr] = i_wdata;
            n_wr++;
        end
    end
endmodule
`default_nettype wire

// *** test/test_exception_stacking_return_token.sv ***
// Random and corner-case bench for the stacking block.
`timescale 1ns/1ns
`default_nettype none
module test_exception_stacking_return_token;
    import esr_pkg::*;
    logic i_clk = 0, i_rst_n = 0, stall = 0, i_entry = 0, i_tail_chain = 0;
    logic i_late_arrival = 0, i_target_secure = 0, i_bg_secure = 0;
    logic i_bg_thread = 0, i_bg_psp = 0, i_fp_active = 0, i_fp_lazy = 0;
    logic i_fp_callee_protect_bit = 0, i_fp_wipe_on_return_bit = 0;
    logic i_pc_load = 0, i_cur_secure = 0, i_mem_ready;
    logic [31:0] i_sp_main_s = 32'h20008000, i_sp_proc_s = 32'h20006000;
    logic [31:0] i_sp_main_ns = 32'h30004000, i_sp_proc_ns = 32'h30002000;
    logic [31:0] i_pc_value = 0, i_stacked_sig = SIG_NO_FP, i_reg_rdata;
    logic [31:0] o_mem_addr, o_mem_wdata, o_lr_value, lfsr = 32'h0000001B;
    logic [5:0]  o_reg_sel;
    logic o_mem_write, o_lr_write, o_handler_msp_s, o_lazy_pending;
    logic o_ret_start, o_ret_fault, o_fp_wipe, o_busy, o_callee_stacked;
    int   fail_count = 0, total_checks = 0;
    esr_stacker dut_u (.*);
    esr_bank_mem_model bank_u (.i_clk(i_clk), .i_stall(stall),
        .i_sel(o_reg_sel), .i_wr(o_mem_write), .i_addr(o_mem_addr),
        .i_wdata(o_mem_wdata), .o_rdata(i_reg_rdata), .o_ready(i_mem_ready));
    initial forever #50 i_clk = ~i_clk;
    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Token expected from the sampled entry conditions.
    function automatic logic [31:0] exp_token(input logic default_callee_push_flag);
        return TOK_BASE | {25'h0, i_bg_secure, default_callee_push_flag, !i_fp_active,
            i_bg_thread, i_bg_psp, 1'b0, i_target_secure};
    endfunction
    // Words pushed by a fresh entry.
    function automatic logic [31:0] exp_words();
        return 8 + ((i_fp_active && !i_fp_lazy) ? 18 : 0)
            + ((i_bg_secure && !i_target_secure) ? 10 : 0)
            + ((i_fp_active && i_bg_secure && i_fp_callee_protect_bit) ? 16 : 0);
    endfunction
    task automatic check(input string what, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Bounded wait for the token pulse, seen where outputs are settled.
    task automatic wait_token();
        for (int n = 0; o_lr_write !== 1'b1; n++) begin
            if (n > 500) begin
                fail_count++;
                tally_and_finish();
            end
            @(negedge i_clk);
        end
    endtask
    // One entry; a repeated request while busy must be ignored.
    task automatic entry(input logic tc, la, default_callee_push_flag, dup, input int w);
        logic [31:0] sp;
        sp = i_bg_secure ? (i_bg_psp ? i_sp_proc_s : i_sp_main_s)
                         : (i_bg_psp ? i_sp_proc_ns : i_sp_main_ns);
        bank_u.mem.delete();
        bank_u.n_wr = 0;
        i_tail_chain = tc;
        i_late_arrival = la;
        i_entry = 1;
        @(negedge i_clk);
        i_entry = dup;
        @(negedge i_clk);
        i_entry = 0;
        wait_token();
        check("token", o_lr_value, exp_token(default_callee_push_flag));
        check("handler stack", o_handler_msp_s, i_target_secure);
        if (w != 0) check("words", bank_u.n_wr, w);
        if (!tc && !la) begin
            check("frame low", bank_u.mem[sp - 32], 32'hC0DE0000);
            check("frame top", bank_u.mem[sp - 4], 32'hC0DE0007);
            check("lazy", o_lazy_pending, i_fp_active && i_fp_lazy);
            check("callee", o_callee_stacked, i_bg_secure && !i_target_secure);
        end
        @(negedge i_clk);
        check("idle", o_busy, 1'b0);
        $display("entry done tc=%0d la=%0d", tc, la);
    endtask
    // One PC load and the expected return outcome.
    task automatic ret(input logic [31:0] v, input logic cs, wp, st, ft);
        i_pc_value = v;
        i_cur_secure = cs;
        i_fp_wipe_on_return_bit = wp;
        i_pc_load = 1;
        @(negedge i_clk);
        i_pc_load = 0;
        check("ret start", o_ret_start, st);
        check("ret fault", o_ret_fault, ft);
        @(negedge i_clk);
        check("fp wipe", o_fp_wipe, st && wp);
        $display("return done %h", v);
        @(negedge i_clk);
    endtask
    initial begin
        repeat (20) @(negedge i_clk);
        i_rst_n = 1;
        check("reset token", o_lr_value, 32'hFFFFFFB8);
        check("reset busy", o_busy, 1'b0);
        for (int k = 0; k < 24; k++) begin
            lfsr = nxt(lfsr);
            {i_target_secure, i_bg_secure, i_bg_thread, i_bg_psp, i_fp_active,
                i_fp_lazy, i_fp_callee_protect_bit, stall} = lfsr[7:0];
            entry(0, 0, 1, lfsr[8], exp_words());
        end
        {i_fp_active, i_bg_secure, i_target_secure} = 3'b011;
        entry(0, 0, 1, 0, exp_words());
        i_target_secure = 0;
        entry(1, 0, 1, 0, 10);
        i_target_secure = 1;
        entry(0, 1, 0, 0, 0);
        entry(1, 0, 0, 0, 0);
        ret(32'hFFFFFFBC, 0, 1, 1, 0);
        ret(32'hFFFFFFF9, 1, 0, 1, 0);
        ret(32'hFFFFFF99, 0, 1, 0, 1);
        ret(32'hFFFFFFBD, 0, 0, 0, 1);
        ret(32'h00001001, 0, 1, 0, 0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
